// *** pkg/ahd_pkg.sv ***
package ahd_pkg;

  // ----------------------------------------
  // command codes and feature value
  // ----------------------------------------
  localparam logic [7:0] CMD_FLUSH = 8'he7;
  localparam logic [7:0] CMD_FMT_TRACK = 8'h50;
  localparam logic [7:0] CMD_FMT_UNIT = 8'hf7;
  localparam logic [7:0] CMD_IDENT = 8'hec;
  localparam logic [7:0] CMD_ERASE_PREP = 8'hf3;
  localparam logic [7:0] FMT_UNIT_FEATURE = 8'h11;

  // ----------------------------------------
  // command block register addresses
  // ----------------------------------------
  localparam logic [2:0] REG_FEATURE = 3'h1;
  localparam logic [2:0] REG_COUNT = 3'h2;
  localparam logic [2:0] REG_SECTOR = 3'h3;
  localparam logic [2:0] REG_CYL_LO = 3'h4;
  localparam logic [2:0] REG_CYL_HI = 3'h5;
  localparam logic [2:0] REG_DEV_HEAD = 3'h6;
  localparam logic [2:0] REG_COMMAND = 3'h7;

  // ----------------------------------------
  // status and error fields
  // ----------------------------------------
  localparam int ST_BSY = 7;
  localparam int ST_RDY = 6;
  localparam int ST_DF = 5;
  localparam int ST_DSC = 4;
  localparam int ST_DRQ = 3;
  localparam int ST_ERR = 0;
  localparam int ERR_ABT = 2;
  localparam int DH_LBA = 6;
  localparam logic [7:0] STATUS_RESET = 8'h50;
  localparam logic [7:0] ERROR_RESET = 8'h00;

  // ----------------------------------------
  // geometry and transfer sizes
  // ----------------------------------------
  localparam logic [27:0] SECT_PER_TRACK = 28'h000003f;
  localparam logic [27:0] NUM_HEADS = 28'h0000010;
  localparam logic [7:0] LAST_WORD = 8'hff;

  // ----------------------------------------
  // identify words
  // ----------------------------------------
  localparam logic [15:0] ID_W0 = 16'h045a;
  localparam logic [15:0] ID_W1_CYLS = 16'h3fff;
  localparam logic [15:0] ID_W2_SPIN = 16'h37c8;
  localparam logic [15:0] ID_W2_PLAIN = 16'h37c0;
  localparam logic [15:0] ID_W3_HEADS = 16'h0010;
  localparam logic [15:0] ID_W6 = 16'h003f;
  localparam logic [15:0] ID_W20 = 16'h0003;
  localparam logic [15:0] ID_W21_BUF = 16'h0200;
  localparam logic [15:0] ID_W22 = 16'h0028;
  localparam logic [7:0] ID_W47_HI = 8'h80;
  localparam logic [7:0] ID_MULT_MAX = 8'h10;
  localparam logic [15:0] ID_W49 = 16'h0f00;
  localparam logic [15:0] ID_W89_ERASE = 16'h0020;
  localparam logic [7:0] ID_SIGNATURE = 8'ha5;
  localparam logic [159:0] ID_SERIAL = 160'h0;
  localparam logic [319:0] ID_MODEL = "GENERIC ATA DISK DRIVE                  ";
  localparam logic [7:0] ID_SER_FIRST = 8'h0a;
  localparam logic [7:0] ID_SER_LAST = 8'h13;
  localparam logic [7:0] ID_MOD_FIRST = 8'h1b;
  localparam logic [7:0] ID_MOD_LAST = 8'h2e;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [2:0] {
    S_IDLE, S_FLUSH_WAIT, S_FT_DATA, S_ZERO_REQ, S_ZERO_WAIT, S_FU_MERGE, S_ID_XFER
  } ahd_state_e;

  typedef struct packed {
    logic [7:0] sum;
  } ahd_ident_s;

  typedef struct packed {
    ahd_state_e st;
    logic [7:0] feat;
    logic [7:0] cnt;
    logic [7:0] sec;
    logic [7:0] cyl_lo;
    logic [7:0] cyl_hi;
    logic [7:0] dev_head;
    logic [7:0] status;
    logic [7:0] error;
    logic prep_done;
    logic [27:0] lba;
    logic [27:0] last_lba;
    logic [7:0] wcnt;
    logic [15:0] data;
    logic irq;
    logic flush_req;
    logic zero_wr;
    logic merge_req;
  } ahd_core_s;

endpackage

// *** core/ahd_ident.sv ***
`timescale 1ns/1ps
module ahd_ident (
  // clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // word request
  input wire logic start_i,
  input wire logic load_i,
  input wire logic [7:0] idx_i,
  input wire logic spinup_needed_i,
  // word out
  output logic [15:0] word_o
);

  ahd_pkg::ahd_ident_s st_ff;
  ahd_pkg::ahd_ident_s nxt_st;

  // ----------------------------------------
  // word table
  // ----------------------------------------
  function automatic logic [15:0] id_word(input logic [7:0] idx, input logic [7:0] sum);
    logic [7:0] k;
    k = 8'h00;
    if (idx >= ahd_pkg::ID_MOD_FIRST && idx <= ahd_pkg::ID_MOD_LAST) begin
      k = idx - ahd_pkg::ID_MOD_FIRST;
      return ahd_pkg::ID_MODEL[319 - 16 * k -: 16]; // RQ21
    end
    if (idx >= ahd_pkg::ID_SER_FIRST && idx <= ahd_pkg::ID_SER_LAST) begin
      k = idx - ahd_pkg::ID_SER_FIRST;
      return ahd_pkg::ID_SERIAL[159 - 16 * k -: 16]; // RQ21
    end
    unique case (idx)
      8'h00: return ahd_pkg::ID_W0; // RQ15
      8'h01: return ahd_pkg::ID_W1_CYLS;
      8'h02: return spinup_needed_i ? ahd_pkg::ID_W2_SPIN : ahd_pkg::ID_W2_PLAIN; // RQ16
      8'h03: return ahd_pkg::ID_W3_HEADS;
      8'h06: return ahd_pkg::ID_W6; // RQ17
      8'h14: return ahd_pkg::ID_W20; // RQ20
      8'h15: return ahd_pkg::ID_W21_BUF; // RQ19
      8'h16: return ahd_pkg::ID_W22;
      8'h2f: return {ahd_pkg::ID_W47_HI, ahd_pkg::ID_MULT_MAX}; // RQ18
      8'h31: return ahd_pkg::ID_W49;
      8'h59: return ahd_pkg::ID_W89_ERASE; // RQ22
      8'hff: return {8'(-(sum + ahd_pkg::ID_SIGNATURE)), ahd_pkg::ID_SIGNATURE}; // RQ23
      default: return 16'h0000;
    endcase
  endfunction

  // ----------------------------------------
  // running byte sum
  // ----------------------------------------
  always_comb begin
    nxt_st = st_ff;
    word_o = id_word(idx_i, st_ff.sum);
    if (start_i) begin
      nxt_st.sum = word_o[15:8] + word_o[7:0];
    end else if (load_i && idx_i != ahd_pkg::LAST_WORD) begin
      nxt_st.sum = st_ff.sum + word_o[15:8] + word_o[7:0]; // RQ23
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

endmodule

// *** core/ahd_core.sv ***
`timescale 1ns/1ps
// Behaviour
// RQ1: flush writes cache out before good status
// RQ2: format track writes zeros, no read-back
// RQ3: accept format table sector, then ignore it
// RQ4: track formatted same regardless of numbering
// RQ5: lba from sector, cylinders and head nibble
// RQ6: lba mode formats track holding address
// RQ7: out-of-range format track address aborts; code aborts only when the track's first lba exceeds native_max_lba_i
// RQ8: format unit merges defects then clears sectors
// RQ9: format unit spans zero to native max
// RQ10: format unit without prior prepare aborts
// RQ11: host loads feature 11h for format unit
// RQ12: format unit never raises data request
// RQ13: host times format unit from word 89
// RQ14: identify sends exactly one sector data-in
// RQ15: word 0 marks fixed non-packet drive
// RQ16: word 2 reflects spin-up requirement
// RQ17: word 6 reports 63 sectors per track
// RQ18: word 47 holds 80h and multiple max
// RQ19: word 21 gives buffer size in sectors
// RQ20: word 20 reports controller type 3
// RQ21: serial and model words hold ascii
// RQ22: word 89 gives erase time over two
// RQ23: last word holds signature and checksum
// RQ24: completion clears busy, flags error, interrupts
module ahd_core (
  // clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // command block register writes and status read
  input wire logic reg_wr_i,
  input wire logic [2:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic status_rd_i,
  // data port
  input wire logic data_rd_i,
  input wire logic data_wr_i,
  input wire logic [15:0] data_i,
  // drive configuration
  input wire logic [27:0] native_max_lba_i,
  input wire logic spinup_needed_i,
  // media engine
  input wire logic cache_dirty_i,
  input wire logic flush_done_i,
  input wire logic zero_done_i,
  input wire logic merge_done_i,
  // register file and interrupt
  output logic [7:0] status_o,
  output logic [7:0] error_o,
  output logic [15:0] data_o,
  output logic irq_o,
  // media requests
  output logic flush_req_o,
  output logic zero_wr_o,
  output logic [27:0] zero_lba_o,
  output logic merge_req_o
);

  ahd_pkg::ahd_core_s st_ff;
  ahd_pkg::ahd_core_s nxt_st;
  logic cmd_go;
  logic [7:0] cmd;
  logic [27:0] trk_start;
  logic [27:0] trk_end;
  logic id_start;
  logic id_load;
  logic [7:0] id_idx;
  logic [15:0] id_word;

  // ----------------------------------------
  // address helpers
  // ----------------------------------------
  function automatic logic [27:0] track_start(input logic [7:0] sec, input logic [7:0] cl,
                                               input logic [7:0] ch, input logic [7:0] dh);
    logic [27:0] lba;
    logic [27:0] chs;
    lba = {dh[3:0], ch, cl, sec}; // RQ5
    chs = ({12'h000, ch, cl} * ahd_pkg::NUM_HEADS + {24'h000000, dh[3:0]})
          * ahd_pkg::SECT_PER_TRACK;
    if (dh[ahd_pkg::DH_LBA]) begin
      return lba - (lba % ahd_pkg::SECT_PER_TRACK); // RQ6
    end
    return chs;
  endfunction

  function automatic logic [7:0] done_status(input logic err);
    logic [7:0] s;
    s = 8'h00;
    s[ahd_pkg::ST_RDY] = 1'b1;
    s[ahd_pkg::ST_DSC] = 1'b1;
    s[ahd_pkg::ST_ERR] = err;
    return s;
  endfunction

  function automatic logic [7:0] xfer_status();
    logic [7:0] s;
    s = done_status(1'b0);
    s[ahd_pkg::ST_DRQ] = 1'b1;
    return s;
  endfunction

  function automatic logic [7:0] busy_status();
    logic [7:0] s;
    s = done_status(1'b0);
    s[ahd_pkg::ST_BSY] = 1'b1;
    return s;
  endfunction

  assign cmd = reg_wdata_i;
  assign cmd_go = reg_wr_i && reg_addr_i == ahd_pkg::REG_COMMAND && st_ff.st == ahd_pkg::S_IDLE;
  assign trk_start = track_start(st_ff.sec, st_ff.cyl_lo, st_ff.cyl_hi, st_ff.dev_head);
  assign trk_end = (trk_start + ahd_pkg::SECT_PER_TRACK - 28'h0000001 > native_max_lba_i)
                   ? native_max_lba_i : trk_start + ahd_pkg::SECT_PER_TRACK - 28'h0000001;
  assign id_start = cmd_go && cmd == ahd_pkg::CMD_IDENT;
  assign id_load = id_start || (st_ff.st == ahd_pkg::S_ID_XFER && data_rd_i
                                && st_ff.wcnt != ahd_pkg::LAST_WORD);
  assign id_idx = id_start ? 8'h00 : (id_load ? st_ff.wcnt + 8'h01 : st_ff.wcnt);

  // ----------------------------------------
  // identify word source
  // ----------------------------------------
  ahd_ident u_ident (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .start_i(id_start),
    .load_i(id_load),
    .idx_i(id_idx),
    .spinup_needed_i(spinup_needed_i),
    .word_o(id_word)
  );

  // ----------------------------------------
  // command sequencer
  // ----------------------------------------
  always_comb begin
    nxt_st = st_ff;
    nxt_st.flush_req = 1'b0;
    nxt_st.zero_wr = 1'b0;
    nxt_st.merge_req = 1'b0;
    if (status_rd_i) begin
      nxt_st.irq = 1'b0;
    end
    if (reg_wr_i && st_ff.st == ahd_pkg::S_IDLE) begin
      unique case (reg_addr_i)
        ahd_pkg::REG_FEATURE: nxt_st.feat = reg_wdata_i;
        ahd_pkg::REG_COUNT: nxt_st.cnt = reg_wdata_i;
        ahd_pkg::REG_SECTOR: nxt_st.sec = reg_wdata_i;
        ahd_pkg::REG_CYL_LO: nxt_st.cyl_lo = reg_wdata_i;
        ahd_pkg::REG_CYL_HI: nxt_st.cyl_hi = reg_wdata_i;
        ahd_pkg::REG_DEV_HEAD: nxt_st.dev_head = reg_wdata_i;
        default: ;
      endcase
    end
    unique case (st_ff.st)
      ahd_pkg::S_IDLE: begin
        if (cmd_go) begin
          nxt_st.prep_done = cmd == ahd_pkg::CMD_ERASE_PREP;
          nxt_st.error = 8'h00;
          nxt_st.status = busy_status();
          unique case (cmd)
            ahd_pkg::CMD_FLUSH: begin
              if (cache_dirty_i) begin
                nxt_st.flush_req = 1'b1; // RQ1
                nxt_st.st = ahd_pkg::S_FLUSH_WAIT;
              end else begin
                nxt_st.status = done_status(1'b0); // RQ24
                nxt_st.irq = 1'b1;
              end
            end
            ahd_pkg::CMD_FMT_TRACK: begin
              if (trk_start > native_max_lba_i) begin
                nxt_st.error[ahd_pkg::ERR_ABT] = 1'b1; // RQ7
                nxt_st.status = done_status(1'b1);
                nxt_st.irq = 1'b1;
              end else begin
                nxt_st.lba = trk_start; // RQ4
                nxt_st.last_lba = trk_end;
                nxt_st.wcnt = 8'h00;
                nxt_st.status = xfer_status(); // RQ3
                nxt_st.st = ahd_pkg::S_FT_DATA;
              end
            end
            ahd_pkg::CMD_FMT_UNIT: begin
              if (!st_ff.prep_done) begin
                nxt_st.error[ahd_pkg::ERR_ABT] = 1'b1; // RQ10
                nxt_st.status = done_status(1'b1);
                nxt_st.irq = 1'b1;
              end else begin
                nxt_st.merge_req = 1'b1; // RQ8
                nxt_st.st = ahd_pkg::S_FU_MERGE;
              end
            end
            ahd_pkg::CMD_IDENT: begin
              nxt_st.wcnt = 8'h00;
              nxt_st.data = id_word; // RQ14
              nxt_st.status = xfer_status();
              nxt_st.irq = 1'b1;
              nxt_st.st = ahd_pkg::S_ID_XFER;
            end
            ahd_pkg::CMD_ERASE_PREP: begin
              nxt_st.status = done_status(1'b0);
              nxt_st.irq = 1'b1;
            end
            default: begin
              nxt_st.error[ahd_pkg::ERR_ABT] = 1'b1;
              nxt_st.status = done_status(1'b1);
              nxt_st.irq = 1'b1;
            end
          endcase
        end
      end
      ahd_pkg::S_FLUSH_WAIT: begin
        if (flush_done_i) begin
          nxt_st.status = done_status(1'b0); // RQ1
          nxt_st.irq = 1'b1;
          nxt_st.st = ahd_pkg::S_IDLE;
        end
      end
      ahd_pkg::S_FT_DATA: begin
        if (data_wr_i) begin
          nxt_st.wcnt = st_ff.wcnt + 8'h01; // RQ3
          if (st_ff.wcnt == ahd_pkg::LAST_WORD) begin
            nxt_st.status = busy_status();
            nxt_st.st = ahd_pkg::S_ZERO_REQ;
          end
        end
      end
      ahd_pkg::S_ZERO_REQ: begin
        nxt_st.zero_wr = 1'b1; // RQ2
        nxt_st.st = ahd_pkg::S_ZERO_WAIT;
      end
      ahd_pkg::S_ZERO_WAIT: begin
        if (zero_done_i) begin
          if (st_ff.lba == st_ff.last_lba) begin
            nxt_st.status = done_status(1'b0); // RQ24
            nxt_st.irq = 1'b1;
            nxt_st.st = ahd_pkg::S_IDLE;
          end else begin
            nxt_st.lba = st_ff.lba + 28'h0000001;
            nxt_st.st = ahd_pkg::S_ZERO_REQ;
          end
        end
      end
      ahd_pkg::S_FU_MERGE: begin
        if (merge_done_i) begin
          nxt_st.lba = 28'h0000000; // RQ9
          nxt_st.last_lba = native_max_lba_i;
          nxt_st.st = ahd_pkg::S_ZERO_REQ;
        end
      end
      ahd_pkg::S_ID_XFER: begin
        if (data_rd_i) begin
          if (st_ff.wcnt == ahd_pkg::LAST_WORD) begin
            nxt_st.status = done_status(1'b0); // RQ14
            nxt_st.st = ahd_pkg::S_IDLE;
          end else begin
            nxt_st.wcnt = st_ff.wcnt + 8'h01;
            nxt_st.data = id_word;
          end
        end
      end
      default: nxt_st.st = ahd_pkg::S_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      st_ff <= '0;
      st_ff.st <= ahd_pkg::S_IDLE;
      st_ff.status <= ahd_pkg::STATUS_RESET;
      st_ff.error <= ahd_pkg::ERROR_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign status_o = st_ff.status;
  assign error_o = st_ff.error;
  assign data_o = st_ff.data;
  assign irq_o = st_ff.irq;
  assign flush_req_o = st_ff.flush_req;
  assign zero_wr_o = st_ff.zero_wr;
  assign zero_lba_o = st_ff.lba;
  assign merge_req_o = st_ff.merge_req;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  property p_flush_req;
    @(posedge clk_i) disable iff (srst_i)
    cmd_go && cmd == ahd_pkg::CMD_FLUSH && cache_dirty_i |=> flush_req_o ##1 status_o[7];
  endproperty
  a_flush_req: assert property (p_flush_req) else $error("flush not requested"); // RQ1

  property p_flush_hold;
    @(posedge clk_i) disable iff (srst_i)
    st_ff.st == ahd_pkg::S_FLUSH_WAIT && !flush_done_i |=> status_o[7] && !irq_o;
  endproperty
  a_flush_hold: assert property (p_flush_hold) else $error("flush done too early"); // RQ1

  property p_ft_abort;
    @(posedge clk_i) disable iff (srst_i)
    cmd_go && cmd == ahd_pkg::CMD_FMT_TRACK && trk_start > native_max_lba_i
    |=> error_o[2] && status_o[0] && !status_o[7] && irq_o;
  endproperty
  a_ft_abort: assert property (p_ft_abort) else $error("range abort missing"); // RQ7

  property p_zero_range;
    @(posedge clk_i) disable iff (srst_i)
    zero_wr_o |-> zero_lba_o <= native_max_lba_i && !status_o[3];
  endproperty
  a_zero_range: assert property (p_zero_range) else $error("zero write out of range"); // RQ9

  property p_fu_abort;
    @(posedge clk_i) disable iff (srst_i)
    cmd_go && cmd == ahd_pkg::CMD_FMT_UNIT && !st_ff.prep_done
    |=> error_o[2] && status_o[0] && !merge_req_o;
  endproperty
  a_fu_abort: assert property (p_fu_abort) else $error("unprepared format not aborted"); // RQ10

  property p_fu_nodrq;
    @(posedge clk_i) disable iff (srst_i)
    cmd_go && cmd == ahd_pkg::CMD_FMT_UNIT && st_ff.prep_done |=> merge_req_o
    ##0 (!status_o[3] throughout (st_ff.st != ahd_pkg::S_IDLE) [*2]);
  endproperty
  a_fu_nodrq: assert property (p_fu_nodrq) else $error("format unit raised drq"); // RQ12

  property p_id_word0;
    @(posedge clk_i) disable iff (srst_i)
    cmd_go && cmd == ahd_pkg::CMD_IDENT |=> data_o == ahd_pkg::ID_W0 && status_o[3];
  endproperty
  a_id_word0: assert property (p_id_word0) else $error("identify word 0 wrong"); // RQ15

  property p_id_end;
    @(posedge clk_i) disable iff (srst_i)
    st_ff.st == ahd_pkg::S_ID_XFER && data_rd_i && st_ff.wcnt == ahd_pkg::LAST_WORD
    |=> !status_o[3] && st_ff.st == ahd_pkg::S_IDLE;
  endproperty
  a_id_end: assert property (p_id_end) else $error("identify length wrong"); // RQ14

  property p_done_irq;
    @(posedge clk_i) disable iff (srst_i)
    $rose(irq_o) |-> !status_o[7] && (status_o[0] == (error_o != 8'h00));
  endproperty
  a_done_irq: assert property (p_done_irq) else $error("completion status wrong"); // RQ24

  c_flush: cover property (@(posedge clk_i) disable iff (srst_i)
    st_ff.st == ahd_pkg::S_FLUSH_WAIT && flush_done_i);
  c_ft_done: cover property (@(posedge clk_i) disable iff (srst_i)
    st_ff.st == ahd_pkg::S_ZERO_WAIT && zero_done_i && st_ff.lba == st_ff.last_lba);
  c_fu_merge: cover property (@(posedge clk_i) disable iff (srst_i)
    st_ff.st == ahd_pkg::S_FU_MERGE && merge_done_i);
  c_id_done: cover property (@(posedge clk_i) disable iff (srst_i)
    st_ff.st == ahd_pkg::S_ID_XFER && data_rd_i && st_ff.wcnt == ahd_pkg::LAST_WORD);

endmodule

// *** verification/ahd_media_model.sv ***
`timescale 1ns/1ps
module ahd_media_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // requests and answer delay
  input wire logic flush_req_i,
  input wire logic zero_wr_i,
  input wire logic merge_req_i,
  input wire logic [3:0] dly_i,
  // completions
  output logic flush_done_o,
  output logic zero_done_o,
  output logic merge_done_o
);
  // ----------------------------------------
  // one job at a time, done after dly_i+1 cycles
  // ----------------------------------------
  logic [4:0] cnt_ff;
  logic [2:0] kind_ff;

  always_ff @(posedge clk_i) begin
    flush_done_o <= 1'b0;
    zero_done_o <= 1'b0;
    merge_done_o <= 1'b0;
    if (srst_i) begin
      cnt_ff <= 5'h00;
      kind_ff <= 3'h0;
    end else if (flush_req_i | zero_wr_i | merge_req_i) begin
      cnt_ff <= {1'b0, dly_i} + 5'h01;
      kind_ff <= {flush_req_i, zero_wr_i, merge_req_i};
    end else if (cnt_ff != 5'h00) begin
      cnt_ff <= cnt_ff - 5'h01;
      if (cnt_ff == 5'h01) begin
        {flush_done_o, zero_done_o, merge_done_o} <= kind_ff;
      end
    end
  end
endmodule

// *** verification/disk_format_flush_identify_cmds_tb.sv ***
`timescale 1ns/1ps
module disk_format_flush_identify_cmds_tb;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  typedef struct {
    logic [7:0] cmd;
    logic dirty;
    logic [27:0] max;
    logic [7:0] st;
    logic [7:0] er;
    int nz;
    int nf;
    int nm;
  } ahd_row_s;
  typedef struct {
    logic [7:0] s, cl, ch, dh;
    logic [27:0] max, first, last;
    int n;
  } ahd_ft_s;
  logic clk_i, srst_i, reg_wr_i, status_rd_i, data_rd_i, data_wr_i;
  logic spinup_needed_i, cache_dirty_i, flush_done_i, zero_done_i, merge_done_i;
  logic [2:0] reg_addr_i;
  logic [7:0] reg_wdata_i, status_o, error_o, sum;
  logic [15:0] data_i, data_o;
  logic [27:0] native_max_lba_i, zero_lba_o, first_lba, last_lba;
  logic irq_o, flush_req_o, zero_wr_o, merge_req_o, drq_seen;
  logic [3:0] dly;
  logic [15:0] w [256];
  int error_cnt, n_checks, nz, nf, nm;
  ahd_row_s rows [9] = '{
    '{8'hf3, 1'b0, 28'h0000005, 8'h50, 8'h00, 0, 0, 0},
    '{8'he7, 1'b0, 28'h0000005, 8'h50, 8'h00, 0, 0, 0},
    '{8'hf7, 1'b0, 28'h0000005, 8'h51, 8'h04, 0, 0, 0},
    '{8'hf3, 1'b0, 28'h0000005, 8'h50, 8'h00, 0, 0, 0},
    '{8'hf7, 1'b0, 28'h0000005, 8'h50, 8'h00, 6, 0, 1},
    '{8'he7, 1'b1, 28'h0000005, 8'h50, 8'h00, 0, 1, 0},
    '{8'hf3, 1'b0, 28'h0000005, 8'h50, 8'h00, 0, 0, 0},
    '{8'h00, 1'b0, 28'h0000005, 8'h51, 8'h04, 0, 0, 0},
    '{8'hf7, 1'b0, 28'h0000005, 8'h51, 8'h04, 0, 0, 0}};
  ahd_ft_s fts [5] = '{
    '{8'h03, 8'h02, 8'h01, 8'he1, 28'h2000000, 28'h10101e7, 28'h1010225, 63},
    '{8'h03, 8'h02, 8'h01, 8'he1, 28'h1010200, 28'h10101e7, 28'h1010200, 26},
    '{8'h01, 8'h02, 8'h00, 8'ha1, 28'h2000000, 28'h000081f, 28'h000085d, 63},
    '{8'h2a, 8'h02, 8'h00, 8'ha1, 28'h2000000, 28'h000081f, 28'h000085d, 63},
    '{8'h40, 8'h10, 8'h00, 8'he0, 28'h0000fff, 28'h0, 28'h0, 0}};

  ahd_core ahd_core_inst (.clk_i(clk_i), .srst_i(srst_i), .reg_wr_i(reg_wr_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .status_rd_i(status_rd_i),
    .data_rd_i(data_rd_i), .data_wr_i(data_wr_i), .data_i(data_i),
    .native_max_lba_i(native_max_lba_i), .spinup_needed_i(spinup_needed_i),
    .cache_dirty_i(cache_dirty_i), .flush_done_i(flush_done_i), .zero_done_i(zero_done_i),
    .merge_done_i(merge_done_i), .status_o(status_o), .error_o(error_o), .data_o(data_o),
    .irq_o(irq_o), .flush_req_o(flush_req_o), .zero_wr_o(zero_wr_o),
    .zero_lba_o(zero_lba_o), .merge_req_o(merge_req_o));

  ahd_media_model ahd_media_model_inst (.clk_i(clk_i), .srst_i(srst_i),
    .flush_req_i(flush_req_o), .zero_wr_i(zero_wr_o), .merge_req_i(merge_req_o),
    .dly_i(dly), .flush_done_o(flush_done_i), .zero_done_o(zero_done_i),
    .merge_done_o(merge_done_i));

  // ----------------------------------------
  // clock and request monitor
  // ----------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  always @(negedge clk_i) begin
    if (zero_wr_o === 1'b1) begin
      if (nz == 0) first_lba = zero_lba_o;
      last_lba = zero_lba_o;
      nz++;
    end
    if (flush_req_o === 1'b1) nf++;
    if (merge_req_o === 1'b1) nm++;
    if (status_o[3] === 1'b1) drq_seen = 1'b1;
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic stop_test;
    if (error_cnt == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
    #1;
  endtask

  task automatic ack;
    @(posedge clk_i);
    status_rd_i <= 1'b1;
    @(posedge clk_i);
    status_rd_i <= 1'b0;
    #1;
  endtask

  task automatic done(input logic [7:0] st, input logic [7:0] er);
    int i;
    for (i = 0; i < 20000 && (status_o[7] !== 1'b0 || status_o[3] !== 1'b0); i++) begin
      @(posedge clk_i);
      #1;
    end
    if (i == 20000) begin
      error_cnt++;
      stop_test();
    end else begin
      chk(status_o, st);
      chk(error_o, er);
      chk(irq_o, 1'b1);
      ack();
      chk(irq_o, 1'b0);
    end
  endtask

  task automatic ident(input logic spin);
    @(posedge clk_i);
    spinup_needed_i <= spin;
    wr(ahd_pkg::REG_COMMAND, ahd_pkg::CMD_IDENT);
    chk(status_o, 8'h58);
    ack();
    for (int i = 0; i < 256; i++) begin
      w[i] = data_o;
      @(posedge clk_i);
      data_rd_i <= 1'b1;
      @(posedge clk_i);
      data_rd_i <= 1'b0;
      #1;
    end
    chk(status_o, 8'h50);
    chk(irq_o, 1'b0);
    chk({w[0][15], w[0][7], w[0][6]}, 3'b001);
    chk(w[0], ahd_pkg::ID_W0);
    chk(w[2], spin ? 16'h37c8 : 16'h37c0);
    chk(w[6], 16'h003f);
    chk(w[20], 16'h0003);
    chk(w[21], ahd_pkg::ID_W21_BUF);
    chk(w[47], {8'h80, ahd_pkg::ID_MULT_MAX});
    chk(w[89], ahd_pkg::ID_W89_ERASE);
    for (int i = 10; i < 20; i++) chk(w[i], ahd_pkg::ID_SERIAL[159-16*(i-10) -: 16]);
    for (int i = 27; i < 47; i++) chk(w[i], ahd_pkg::ID_MODEL[319-16*(i-27) -: 16]);
    sum = 8'h00;
    for (int i = 0; i < 256; i++) sum = sum + w[i][15:8] + w[i][7:0];
    chk(w[255][7:0], 8'ha5);
    chk(sum, 8'h00);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {reg_wr_i, status_rd_i, data_rd_i, data_wr_i, spinup_needed_i, cache_dirty_i} = 6'h00;
    reg_addr_i = 3'h0;
    reg_wdata_i = 8'h00;
    data_i = 16'h0000;
    native_max_lba_i = 28'h0000005;
    dly = 4'h0;
    {error_cnt, n_checks, nz, nf, nm} = {5{32'sd0}};
    drq_seen = 1'b0;
    srst_i = 1'b1;
    repeat (20) @(posedge clk_i);
    srst_i <= 1'b0;
    #1;
    chk({status_o, error_o, data_o, irq_o}, {8'h50, 8'h00, 16'h0000, 1'b0});
    for (int r = 0; r < 9; r++) begin
      @(posedge clk_i);
      cache_dirty_i <= rows[r].dirty;
      native_max_lba_i <= rows[r].max;
      dly <= 4'(r % 4);
      wr(ahd_pkg::REG_FEATURE, ahd_pkg::FMT_UNIT_FEATURE);
      {nz, nf, nm} = {3{32'sd0}};
      drq_seen = 1'b0;
      wr(ahd_pkg::REG_COMMAND, rows[r].cmd);
      done(rows[r].st, rows[r].er);
      chk(nz, rows[r].nz);
      chk(nf, rows[r].nf);
      chk(nm, rows[r].nm);
      chk(drq_seen, 1'b0);
      if (rows[r].nz != 0) chk({first_lba, last_lba}, {28'h0, rows[r].max});
    end
    for (int k = 0; k < 5; k++) begin
      @(posedge clk_i);
      native_max_lba_i <= fts[k].max;
      dly <= 4'(k);
      wr(ahd_pkg::REG_SECTOR, fts[k].s);
      wr(ahd_pkg::REG_CYL_LO, fts[k].cl);
      wr(ahd_pkg::REG_CYL_HI, fts[k].ch);
      wr(ahd_pkg::REG_DEV_HEAD, fts[k].dh);
      {nz, nf, nm} = {3{32'sd0}};
      wr(ahd_pkg::REG_COMMAND, ahd_pkg::CMD_FMT_TRACK);
      if (fts[k].n == 0) begin
        done(8'h51, 8'h04);
      end else begin
        chk(status_o, 8'h58);
        for (int i = 0; i < 256; i++) begin
          @(posedge clk_i);
          data_wr_i <= 1'b1;
          data_i <= 16'hff00 ^ 16'(i);
          @(posedge clk_i);
          data_wr_i <= 1'b0;
        end
        #1;
        done(8'h50, 8'h00);
        chk({first_lba, last_lba}, {fts[k].first, fts[k].last});
      end
      chk(nz, fts[k].n);
    end
    ident(1'b0);
    ident(1'b1);
    stop_test();
  end
endmodule
